// ==== hdl/disk_xfer_consts.svh ====
`ifndef DISK_XFER_CONSTS_SVH
`define DISK_XFER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets on the host port
// ----------------------------------------------------------------------
`define OFS_DATA        3'h0
`define OFS_ERROR       3'h1
`define OFS_SECT_COUNT  3'h2
`define OFS_SECT_NUMBER 3'h3
`define OFS_CYL_LOW     3'h4
`define OFS_CYL_HIGH    3'h5
`define OFS_SDH         3'h6
`define OFS_CMD_STATUS  3'h7

// ----------------------------------------------------------------------
// Status and command fields
// ----------------------------------------------------------------------
`define ST_BUSY_BIT     7
`define ST_DRQ_BIT      3
`define ST_CORR_BIT     2
`define ST_ERR_BIT      0
`define CMD_CLASS_BIT   4
`define CMD_DMA_BIT     3
`define CMD_OPC_HI      7
`define CMD_OPC_LO      5
`define OPC_SECTOR      3'h1
`define OPC_FORMAT      3'h2
`define SDH_HEAD_HI     2

// ----------------------------------------------------------------------
// Reset values and buffer size
// ----------------------------------------------------------------------
`define TASK_RST        8'h00
`define COUNT_RST       8'h01
`define LAST_BYTE_IDX   8'hff
`define SECTOR_BYTES    256

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define BYTE_GAP_NS     1750
`define BYTE_GAP_CYC    ((`BYTE_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hdl/sector_xfer_pkg.sv ====
package sector_xfer_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ_DISK,
    ST_READ_XFER,
    ST_WRITE_FILL,
    ST_WRITE_DISK,
    ST_OTHER_DISK
  } xfer_state_t;

  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_FORMAT,
    OP_OTHER
  } disk_op_t;

  typedef struct packed {
    disk_op_t    op;
    logic        implied_seek;
    logic [7:0]  cyl_high;
    logic [7:0]  cyl_low;
    logic [2:0]  head;
    logic [7:0]  sector;
    logic [7:0]  count;
  } disk_req_t;

  typedef struct packed {
    logic        done;
    logic        fatal;
    logic        corrected;
    logic [7:0]  err_code;
  } disk_status_t;

endpackage : sector_xfer_pkg

// ==== hdl/disk_sector_host_transfer.sv ====
`include "disk_xfer_consts.svh"

// Function
// - Read sector is the only buffer-to-host command
// - Non-DMA read interrupts before buffer transfer
// - DMA read interrupts after whole buffer moved
// - DMA buffer bytes available, no faster than 1.75us
// - Request line rises once per DMA byte
// - Multi-sector only with DMA; zero means 256
// - Read/write success leaves count zero, sector past last; format and other leave both
// - Fatal error freezes sector and remaining count
// - Correctable error sets flag, transfer continues
// - Host may read partial sector, discard rest
// - Command bit 4 separates read from others
// - Cylinder-low access clears the request line
// - Errors complete identically, shown by error bit
// - Write and format fill buffer from host
// - Busy bit 7 marks a disk operation
// - Attention line rises when host intervention needed
// - Error register meaningful only with error bit
module disk_sector_host_transfer (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic [2:0]                   addr_i,
  input  wire logic [7:0]                   wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic [7:0]                        rdata_o,
  output logic                              byte_transfer_request_o,
  output logic                              host_attention_line_o,
  output logic                              disk_start_o,
  output sector_xfer_pkg::disk_req_t        disk_req_o,
  input  wire sector_xfer_pkg::disk_status_t disk_status_i,
  input  wire logic                         disk_wr_i,
  input  wire logic [7:0]                   disk_addr_i,
  input  wire logic [7:0]                   disk_wdata_i,
  output logic [7:0]                        disk_rdata_o
);
  import sector_xfer_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  xfer_state_t  state_reg;
  logic [7:0]   cmd_reg;
  logic [7:0]   count_reg;
  logic [7:0]   sector_reg;
  logic [7:0]   cyl_low_reg;
  logic [7:0]   cyl_high_reg;
  logic [7:0]   sdh_reg;
  logic [7:0]   err_code_reg;
  logic         err_reg;
  logic         corr_reg;
  logic [7:0]   idx_reg;
  logic [7:0]   pace_reg;
  logic         drq_reg;
  logic         drq_hold_reg;
  logic         int_reg;
  logic [7:0]   rdata_reg;
  logic [7:0]   disk_rdata_reg;
  logic         start_reg;
  logic [7:0]   buf_mem [`SECTOR_BYTES];

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  logic         busy;
  logic         dma;
  logic         data_rd;
  logic         data_wr;
  logic         cyl_low_acc;
  logic         cmd_wr;
  logic         task_wr;
  logic         last_byte;
  logic         drain_done;
  logic         fill_done;
  logic         more_sectors;
  logic         disk_done;
  logic         read_again;
  logic         write_again;
  logic         int_set;
  logic         start_next;
  disk_op_t     cmd_op;
  disk_op_t     new_op;
  logic [7:0]   status_byte;

  function automatic disk_op_t op_of(input logic [7:0] cmd);
    if (!cmd[`CMD_CLASS_BIT]) begin
      op_of = OP_READ;
    end else if (cmd[`CMD_OPC_HI:`CMD_OPC_LO] == `OPC_SECTOR) begin
      op_of = OP_WRITE;
    end else if (cmd[`CMD_OPC_HI:`CMD_OPC_LO] == `OPC_FORMAT) begin
      op_of = OP_FORMAT;
    end else begin
      op_of = OP_OTHER;
    end
  endfunction

  assign busy = (state_reg == ST_READ_DISK) || (state_reg == ST_WRITE_DISK) ||
                (state_reg == ST_OTHER_DISK);
  assign dma          = cmd_reg[`CMD_DMA_BIT];
  assign cmd_op       = op_of(cmd_reg);
  assign new_op       = op_of(wdata_i);
  assign data_rd      = rd_i && (addr_i == `OFS_DATA);
  assign data_wr      = wr_i && (addr_i == `OFS_DATA);
  assign cyl_low_acc  = (rd_i || wr_i) && (addr_i == `OFS_CYL_LOW);
  // Task file is frozen while the disk side is working on it
  assign task_wr      = wr_i && !busy;
  assign cmd_wr       = task_wr && (addr_i == `OFS_CMD_STATUS);
  assign last_byte    = (idx_reg == `LAST_BYTE_IDX);
  assign drain_done   = (state_reg == ST_READ_XFER) && data_rd && last_byte;
  assign fill_done    = (state_reg == ST_WRITE_FILL) && data_wr && last_byte;
  assign disk_done    = busy && disk_status_i.done;
  // Count of one is the final record; zero wraps through 256
  assign more_sectors = dma && (count_reg != 8'h01);
  assign read_again   = drain_done && !err_reg && more_sectors;
  assign write_again  = (state_reg == ST_WRITE_DISK) && disk_done &&
                        !disk_status_i.fatal && (cmd_op == OP_WRITE) && more_sectors;

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else if (cmd_wr) begin
      // Idle, or abandoning a partly read or partly filled buffer
      case (new_op)
        OP_READ:   state_reg <= ST_READ_DISK;
        OP_WRITE:  state_reg <= ST_WRITE_FILL;
        OP_FORMAT: state_reg <= ST_WRITE_FILL;
        default:   state_reg <= ST_OTHER_DISK;
      endcase
    end else begin
      case (state_reg)
        ST_READ_DISK: begin
          if (disk_done) begin
            state_reg <= ST_READ_XFER;
          end
        end
        ST_READ_XFER: begin
          if (read_again) begin
            state_reg <= ST_READ_DISK;
          end else if (drain_done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WRITE_FILL: begin
          if (fill_done) begin
            state_reg <= ST_WRITE_DISK;
          end
        end
        ST_WRITE_DISK: begin
          if (write_again) begin
            state_reg <= ST_WRITE_FILL;
          end else if (disk_done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_OTHER_DISK: begin
          if (disk_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign start_next = (cmd_wr && (new_op == OP_READ || new_op == OP_OTHER)) ||
                      read_again || fill_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
    end
  end

  // --------------------------------------------------------------------
  // Task file
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg      <= `TASK_RST;
      cyl_low_reg  <= `TASK_RST;
      cyl_high_reg <= `TASK_RST;
      sdh_reg      <= `TASK_RST;
    end else if (task_wr) begin
      case (addr_i)
        `OFS_CMD_STATUS: cmd_reg      <= wdata_i;
        `OFS_CYL_LOW:    cyl_low_reg  <= wdata_i;
        `OFS_CYL_HIGH:   cyl_high_reg <= wdata_i;
        `OFS_SDH:        sdh_reg      <= wdata_i;
        default:         cmd_reg      <= cmd_reg;
      endcase
    end
  end

  // Sector pointer moves only after a record fully succeeds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg  <= `COUNT_RST;
      sector_reg <= `TASK_RST;
    end else if (task_wr && addr_i == `OFS_SECT_COUNT) begin
      count_reg  <= wdata_i;
    end else if (task_wr && addr_i == `OFS_SECT_NUMBER) begin
      sector_reg <= wdata_i;
    end else if ((drain_done && !err_reg) || write_again ||
                 ((state_reg == ST_WRITE_DISK) && disk_done && !disk_status_i.fatal &&
                  (cmd_op == OP_WRITE))) begin
      count_reg  <= count_reg - 8'h01;
      sector_reg <= sector_reg + 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // Error and corrected flags
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_reg      <= 1'b0;
      corr_reg     <= 1'b0;
      err_code_reg <= `TASK_RST;
    end else if (cmd_wr) begin
      err_reg      <= 1'b0;
      corr_reg     <= 1'b0;
    end else if (disk_done) begin
      if (disk_status_i.fatal) begin
        err_reg      <= 1'b1;
        err_code_reg <= disk_status_i.err_code;
      end
      if (disk_status_i.corrected) begin
        corr_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Host attention line
  // --------------------------------------------------------------------
  assign int_set = ((state_reg == ST_READ_DISK) && disk_done && !dma) ||
                   (drain_done && dma && !read_again) ||
                   ((state_reg == ST_WRITE_DISK) && disk_done && !write_again) ||
                   ((state_reg == ST_OTHER_DISK) && disk_done);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_reg <= 1'b0;
    end else if (int_set) begin
      int_reg <= 1'b1;
    end else if (cmd_wr || (rd_i && addr_i == `OFS_CMD_STATUS)) begin
      int_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Buffer index and storage
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || cmd_wr) begin
      idx_reg <= 8'h00;
    end else if (((state_reg == ST_READ_XFER) && data_rd) ||
                 ((state_reg == ST_WRITE_FILL) && data_wr)) begin
      // Wraps to zero after the last byte, ready for the next record
      idx_reg <= idx_reg + 8'h01;
    end
  end

  generate
    for (genvar g = 0; g < `SECTOR_BYTES; g++) begin : g_buf
      always_ff @(posedge clk_i) begin
        if ((state_reg == ST_WRITE_FILL) && data_wr && idx_reg == 8'(g)) begin
          buf_mem[g] <= wdata_i;
        end else if ((state_reg == ST_READ_DISK) && disk_wr_i &&
                     disk_addr_i == 8'(g)) begin
          buf_mem[g] <= disk_wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disk_rdata_reg <= 8'h00;
    end else begin
      disk_rdata_reg <= buf_mem[disk_addr_i];
    end
  end

  // --------------------------------------------------------------------
  // Byte request pacing
  // --------------------------------------------------------------------
  // The gap is enforced from each access; a slower master just waits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pace_reg <= 8'h00;
    end else if (data_rd || data_wr) begin
      pace_reg <= 8'(`BYTE_GAP_CYC - 1);
    end else if (pace_reg != 8'h00) begin
      pace_reg <= pace_reg - 8'h01;
    end
  end

  // Hold keeps a stale request from re-arming until a new command
  always_ff @(posedge clk_i) begin
    if (rst_i || cmd_wr) begin
      drq_hold_reg <= 1'b0;
    end else if (cyl_low_acc) begin
      drq_hold_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drq_reg <= 1'b0;
    end else if (data_rd || data_wr || cyl_low_acc || cmd_wr) begin
      drq_reg <= 1'b0;
    end else if (dma && !drq_hold_reg && pace_reg == 8'h00 &&
                 ((state_reg == ST_READ_XFER) || (state_reg == ST_WRITE_FILL))) begin
      drq_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  assign status_byte = {busy, 3'b000,
                        (state_reg == ST_READ_XFER) || (state_reg == ST_WRITE_FILL),
                        corr_reg, 1'b0, err_reg};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_DATA:        rdata_reg <= (state_reg == ST_READ_XFER) ?
                                       buf_mem[idx_reg] : 8'h00;
        `OFS_ERROR:       rdata_reg <= err_code_reg;
        `OFS_SECT_COUNT:  rdata_reg <= count_reg;
        `OFS_SECT_NUMBER: rdata_reg <= sector_reg;
        `OFS_CYL_LOW:     rdata_reg <= cyl_low_reg;
        `OFS_CYL_HIGH:    rdata_reg <= cyl_high_reg;
        `OFS_SDH:         rdata_reg <= sdh_reg;
        `OFS_CMD_STATUS:  rdata_reg <= status_byte;
        default:          rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign rdata_o                 = rdata_reg;
  assign byte_transfer_request_o = drq_reg;
  assign host_attention_line_o   = int_reg;
  assign disk_start_o            = start_reg;
  assign disk_rdata_o            = disk_rdata_reg;

  always_comb begin
    disk_req_o              = '0;
    disk_req_o.op           = cmd_op;
    disk_req_o.implied_seek = (cmd_op != OP_OTHER);
    disk_req_o.cyl_high     = cyl_high_reg;
    disk_req_o.cyl_low      = cyl_low_reg;
    disk_req_o.head         = sdh_reg[`SDH_HEAD_HI:0];
    disk_req_o.sector       = sector_reg;
    disk_req_o.count        = count_reg;
  end

endmodule // disk_sector_host_transfer

// ==== sim/disk_xfer_assertions.sv ====
`include "disk_xfer_consts.svh"
module disk_xfer_checker (
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic [2:0]                    addr_i,
  input wire logic [7:0]                    wdata_i,
  input wire logic                          wr_i,
  input wire logic                          rd_i,
  input wire logic [7:0]                    rdata_o,
  input wire logic                          byte_transfer_request_o,
  input wire logic                          host_attention_line_o,
  input wire logic                          disk_start_o,
  input wire sector_xfer_pkg::disk_req_t    disk_req_o,
  input wire sector_xfer_pkg::disk_status_t disk_status_i,
  input wire logic                          disk_wr_i,
  input wire logic [7:0]                    disk_addr_i,
  input wire logic [7:0]                    disk_wdata_i,
  input wire logic [7:0]                    disk_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import sector_xfer_pkg::*;
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic       busy_h;
  logic       dma_h;
  logic       rd_done;
  logic [7:0] gap_cnt;
  logic       cyl_hold;
  assign rd_done = busy_h && disk_status_i.done && disk_req_o.op == OP_READ;
  always_ff @(posedge clk_i) begin
    if (rst_i) busy_h <= 1'b0;
    else if (disk_start_o) busy_h <= 1'b1;
    else if (disk_status_i.done) busy_h <= 1'b0;
  end
  // Misses the one cycle between fill and start; bench never writes then
  always_ff @(posedge clk_i) begin
    if (rst_i) dma_h <= 1'b0;
    else if (wr_i && addr_i == `OFS_CMD_STATUS && !busy_h) dma_h <= wdata_i[`CMD_DMA_BIT];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) gap_cnt <= 8'hff;
    else if ((rd_i || wr_i) && addr_i == `OFS_DATA) gap_cnt <= 8'h00;
    else if (gap_cnt != 8'hff) gap_cnt <= gap_cnt + 8'h01;
  end
  // Any command write frees it; a refused one only weakens the check
  always_ff @(posedge clk_i) begin
    if (rst_i) cyl_hold <= 1'b0;
    else if (wr_i && addr_i == `OFS_CMD_STATUS) cyl_hold <= 1'b0;
    else if ((rd_i || wr_i) && addr_i == `OFS_CYL_LOW) cyl_hold <= 1'b1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_start_once: assert property (disk_start_o |=> !disk_start_o)
    else $error("start pulse too long");
  a_read_start: assert property (wr_i && addr_i == `OFS_CMD_STATUS &&
    !wdata_i[`CMD_CLASS_BIT] && !busy_h |=> disk_start_o && disk_req_o.op == OP_READ)
    else $error("read not started");
  a_implied_seek: assert property (disk_start_o && disk_req_o.op != OP_OTHER
    |-> disk_req_o.implied_seek) else $error("seek not implied");
  a_cyl_clear: assert property ((rd_i || wr_i) && addr_i == `OFS_CYL_LOW
    |=> !byte_transfer_request_o) else $error("request not cleared");
  a_cyl_hold: assert property (cyl_hold |-> !byte_transfer_request_o)
    else $error("request back before command");
  a_req_drop: assert property ((rd_i || wr_i) && addr_i == `OFS_DATA
    |=> !byte_transfer_request_o [*8]) else $error("request not dropped");
  a_req_gap: assert property ($rose(byte_transfer_request_o) |->
    gap_cnt >= 8'(`BYTE_GAP_CYC)) else $error("byte pace too fast");
  a_req_dma: assert property (byte_transfer_request_o |-> dma_h)
    else $error("request outside dma");
  a_pio_attn: assert property (rd_done && !dma_h |=> host_attention_line_o)
    else $error("early attention missing");
  a_dma_attn: assert property (rd_done && dma_h
    |=> !host_attention_line_o ##[0:3] byte_transfer_request_o) else $error("dma attention early");
  a_other_attn: assert property (busy_h && disk_status_i.done &&
    (disk_req_o.op == OP_OTHER || disk_req_o.op == OP_FORMAT) |=> host_attention_line_o)
    else $error("attention missing");
endmodule // disk_xfer_checker

// ==== sim/disk_model.sv ====
module disk_model #(
  parameter logic [7:0] ERR_CODE = 8'h3c
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          start_i,
  input  wire sector_xfer_pkg::disk_req_t    req_i,
  input  wire logic                          fatal_i,
  input  wire logic                          corr_i,
  input  wire logic [3:0]                    lat_i,
  output sector_xfer_pkg::disk_status_t      status_o,
  output logic                               wr_o,
  output logic [7:0]                         addr_o,
  output logic [7:0]                         wdata_o,
  input  wire logic [7:0]                    rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import sector_xfer_pkg::*;
  // ----------------------------------------------------------------
  // Drive side: fills or drains the buffer, then reports
  // ----------------------------------------------------------------
  logic [7:0] seen [256];
  initial begin
    status_o = '0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    forever begin
      @(posedge clk_i);
      if (start_i && !rst_i) begin
        repeat (lat_i) @(posedge clk_i);
        for (int i = 0; i < 257; i++) begin
          wr_o <= (req_i.op == OP_READ) && i < 256;
          wdata_o <= req_i.sector ^ i[7:0] ^ 8'ha5;
          addr_o <= i[7:0];
          @(posedge clk_i);
          if (i > 0) seen[i - 1] = rdata_i;
        end
        // Stale data inverted so a late sample cannot pass by luck
        wr_o <= 1'b0;
        wdata_o <= ~wdata_o;
        status_o <= {1'b1, fatal_i, corr_i, fatal_i ? ERR_CODE : 8'h00};
        @(posedge clk_i);
        status_o <= '0;
      end
    end
  end
endmodule // disk_model

// ==== sim/disk_sector_host_transfer_tb.sv ====
`include "disk_xfer_consts.svh"
module disk_sector_host_transfer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sector_xfer_pkg::*;
  localparam logic [7:0] ERR_CODE = 8'h3c;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, fatal = 0, corr = 0;
  logic [2:0] addr_i = 0;
  logic [3:0] lat = 4'h2;
  logic [7:0] wdata_i = 0, rdata_o, disk_addr_i, disk_wdata_i, disk_rdata_o, v, sec, r;
  logic byte_transfer_request_o, host_attention_line_o, disk_start_o, disk_wr_i;
  logic [7:0] wbuf [256];
  disk_req_t disk_req_o;
  disk_status_t disk_status_i;
  int error_cnt = 0, n_tests = 0, seed = 21;
  always #5 clk_i = ~clk_i;
  disk_sector_host_transfer u_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .byte_transfer_request_o, .host_attention_line_o, .disk_start_o, .disk_req_o,
    .disk_status_i, .disk_wr_i, .disk_addr_i, .disk_wdata_i, .disk_rdata_o);
  disk_model #(.ERR_CODE(ERR_CODE)) u_disk (.clk_i, .rst_i, .start_i(disk_start_o),
    .req_i(disk_req_o), .fatal_i(fatal), .corr_i(corr), .lat_i(lat), .status_o(disk_status_i),
    .wr_o(disk_wr_i), .addr_o(disk_addr_i), .wdata_o(disk_wdata_i), .rdata_i(disk_rdata_o));
  // ----------------------------------------------------------------
  // Host tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    rd(a, v);
    check($sformatf("reg%0d", a), v, exp);
  endtask
  task automatic wait_for(input logic req);
    int k;
    k = 0;
    while ((req ? byte_transfer_request_o : host_attention_line_o) !== 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 3000) check(req ? "request" : "attention", 8'h00, 8'h01);
  endtask
  // Expected byte worked out per sector and index
  function automatic logic [7:0] exp_b(input logic [7:0] s, input int i);
    return s ^ i[7:0] ^ 8'ha5;
  endfunction
  task automatic dma_sector(input logic [7:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      wait_for(1'b1);
      if (i == 255) check("attention", {7'h00, host_attention_line_o}, 8'h00);
      rd(`OFS_DATA, v);
      check("dma data", v, exp_b(s, i));
    end
  endtask
  task automatic start(input logic [7:0] cnt, input logic [7:0] cmd);
    sec = 8'($random(seed));
    lat <= 4'($random(seed));
    wr(`OFS_SECT_COUNT, cnt);
    wr(`OFS_SECT_NUMBER, sec);
    wr(`OFS_CYL_LOW, 8'h00);
    wr(`OFS_CMD_STATUS, cmd);
  endtask
  task automatic results;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(`OFS_SECT_COUNT, `COUNT_RST);
    rchk(`OFS_CMD_STATUS, 8'h00);
    for (int a = 2; a < 6; a++) begin
      r = 8'($random(seed));
      wr(a[2:0], r);
      rchk(a[2:0], r);
    end
    $display("registers done");
    start(8'h01, 8'h20);
    wait_for(1'b0);
    rchk(`OFS_CMD_STATUS, 8'h08);
    for (int i = 0; i < 256; i++) begin
      rd(`OFS_DATA, v);
      check("pio data", v, exp_b(sec, i));
    end
    rchk(`OFS_CMD_STATUS, 8'h00);
    $display("pio read done");
    start(8'h01, 8'h08);
    dma_sector(sec, 3);
    wait_for(1'b1);
    wr(`OFS_CYL_LOW, 8'h00);
    #1 check("request", {7'h00, byte_transfer_request_o}, 8'h00);
    repeat (200) @(posedge clk_i);
    check("request", {7'h00, byte_transfer_request_o}, 8'h00);
    wr(`OFS_CMD_STATUS, 8'h20);
    wait_for(1'b0);
    rchk(`OFS_DATA, exp_b(sec, 0));
    $display("partial read done");
    corr <= 1'b1;
    start(8'h02, 8'h08);
    dma_sector(sec, 256);
    corr <= 1'b0;
    fatal <= 1'b1;
    dma_sector(sec + 8'h01, 256);
    wait_for(1'b0);
    rchk(`OFS_CMD_STATUS, 8'h05);
    rchk(`OFS_SECT_COUNT, 8'h01);
    rchk(`OFS_SECT_NUMBER, sec + 8'h01);
    rchk(`OFS_ERROR, ERR_CODE);
    $display("multi sector done");
    start(8'h01, 8'h30);
    rchk(`OFS_CMD_STATUS, 8'h08);
    for (int i = 0; i < 256; i++) begin
      wbuf[i] = 8'($random(seed));
      wr(`OFS_DATA, wbuf[i]);
    end
    wait_for(1'b0);
    rchk(`OFS_CMD_STATUS, 8'h01);
    for (int i = 0; i < 256; i++) check("disk byte", u_disk.seen[i], wbuf[i]);
    check("op", {6'h00, disk_req_o.op}, {6'h00, OP_WRITE});
    $display("write done");
    start(8'h01, 8'h38);
    for (int i = 0; i < 2; i++) begin
      wait_for(1'b1);
      wr(`OFS_DATA, wbuf[i]);
      #1 check("request", {7'h00, byte_transfer_request_o}, 8'h00);
    end
    rchk(`OFS_CMD_STATUS, 8'h08);
    $display("dma write done");
    fatal <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      start(8'h03, k ? 8'h70 : 8'h50);
      if (k == 0) for (int i = 0; i < 256; i++) wr(`OFS_DATA, 8'($random(seed)));
      rchk(`OFS_CMD_STATUS, 8'h80);
      wait_for(1'b0);
      rchk(`OFS_CMD_STATUS, 8'h00);
      check("op", {6'h00, disk_req_o.op}, {6'h00, k ? OP_OTHER : OP_FORMAT});
      rchk(`OFS_SECT_COUNT, 8'h03);
    end
    $display("format and other done");
    results();
  end
  initial begin
    #1000000;
    check("watchdog", 8'h00, 8'h01);
    results();
  end
endmodule // disk_sector_host_transfer_tb
bind disk_sector_host_transfer disk_xfer_checker u_chk (.clk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .byte_transfer_request_o, .host_attention_line_o, .disk_start_o,
  .disk_req_o, .disk_status_i, .disk_wr_i, .disk_addr_i, .disk_wdata_i, .disk_rdata_o);
